// >>> hdl/ufbc_pkg.sv
package ufbc_pkg;

	// Register offsets (byte addresses on the plain register port)
	localparam logic [3:0] OFS_FRAME = 4'h7;
	localparam logic [3:0] OFS_BAUD_LO = 4'h8;
	localparam logic [3:0] OFS_BAUD_HI = 4'h9;
	localparam logic [3:0] OFS_WINDOW = 4'ha;
	localparam logic [3:0] OFS_DBG = 4'hb;
	localparam logic [3:0] OFS_EVC = 4'hc;
	localparam logic [3:0] OFS_PULSE = 4'hd;

	// Reset values
	localparam logic [7:0] RST_FRAME = 8'h03;
	localparam logic [7:0] RST_FRAME_SPI = 8'h00;
	localparam logic [15:0] RST_BAUD = 16'h0000;
	localparam logic [7:0] RST_WINDOW = 8'h00;
	localparam logic [7:0] RST_DBG = 8'h00;
	localparam logic [7:0] RST_EVC = 8'h00;
	localparam logic [7:0] RST_PULSE = 8'h00;

	// Field positions
	localparam int MODE_LSB = 6;
	localparam int PARITY_LSB = 4;
	localparam int STOP_SEL_BIT = 3;
	localparam int SIZE_LSB = 0;
	localparam int ORDER_BIT = 2;
	localparam int PHASE_BIT = 1;
	localparam int WINDOW_LSB = 6;
	localparam int RUN_BIT = 0;
	localparam int EV_DIS_BIT = 0;
	localparam logic [7:0] SPI_VIEW_MASK = 8'hc6;

	// Field codes
	typedef enum logic [1:0] {
		UFBC_MODE_ASYNC = 2'h0,
		UFBC_MODE_SYNC = 2'h1,
		UFBC_MODE_IR = 2'h2,
		UFBC_MODE_SPI = 2'h3
	} ufbc_mode_t;
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_EVEN = 2'h2;
	localparam logic [1:0] PAR_ODD = 2'h3;
	localparam logic [2:0] CH_9BIT_LOW = 3'h6;
	localparam logic [2:0] CH_9BIT_HIGH = 3'h7;
	localparam logic [1:0] RX_CONSTRAINED = 2'h3;

	// Timing counts
	localparam int SAMPLES_PER_BIT = 16;
	localparam logic [5:0] PAIR_SAMPLES = 6'h20;
	localparam logic [7:0] PULSE_FRACTION = 8'h00;
	localparam logic [7:0] PULSE_PASS = 8'hff;
	localparam logic [7:0] FRACTION_SAMPLES = 8'h03;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ufbc_bus_req_t;

	typedef struct packed {
		ufbc_mode_t mode;
		logic parity_en;
		logic parity_odd;
		logic two_stop_tx;
		logic [3:0] data_bits;
		logic nine_bit;
		logic nine_high_first;
		logic spi_lsb_first;
		logic spi_sample_trailing;
	} ufbc_frame_cfg_t;

	typedef struct packed {
		logic active;
		logic [5:0] min_samples;
		logic [5:0] max_samples;
	} ufbc_window_t;

	typedef enum logic {
		UFBC_IR_IDLE = 1'b0,
		UFBC_IR_PULSE = 1'b1
	} ufbc_ir_state_t;

endpackage

// >>> hdl/ufbc_core.sv
// Function
// - Parity code 0 none, 2 even, 3 odd; code 1 reserved.
// - Transmitter sends one stop bit for select 0, two for select 1.
// - Receiver checks frames the same whatever the stop-bit select holds.
// - Character size codes 0 to 3 give 5 to 8 data bits.
// - Transmitter and receiver share one character size setting.
// - Code 6 is nine bits low byte first, code 7 high byte first.
// - Mode codes: 0 async, 1 sync, 2 infrared, 3 host SPI.
// - Host SPI view shows only mode, data order bit 2, phase bit 1.
// - Data order 0 sends MSB first, 1 LSB first, both directions.
// - A new data order applies at once, even mid frame.
// - Clock phase 0 samples on leading edge, 1 on trailing edge.
// - Baud divisor is 16 bits, low byte at 0x08, high next.
// - Any divisor write reloads the prescaler at once.
// - Window codes 0 to 3 accept 32 plus or minus 6, 5, 7, 8.
// - Sixteen samples per bit, so 32 samples per bit pair.
// - Debug-run 0 halts and ignores events while the CPU is stopped.
// - Infrared event input bit 0 enables the input, 1 disables it.
// - Pulse code 0 is 3/16 bit, 1..FE clocks, FF passes through.
// - Receiver mode 3 selects constrained auto-baud using the window.
`timescale 1ns/1ps
`default_nettype none

module ufbc_core #(
	parameter int SAMPLES_PER_BIT = ufbc_pkg::SAMPLES_PER_BIT
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic ce,
	input wire ufbc_pkg::ufbc_bus_req_t req,
	input wire logic [1:0] receiver_speed_mode,
	input wire logic cpu_halted,
	input wire logic tx_line,
	output logic [7:0] rdata,
	output ufbc_pkg::ufbc_frame_cfg_t cfg,
	output ufbc_pkg::ufbc_window_t win,
	output logic [15:0] baud_div,
	output logic sample_tick,
	output logic bit_tick,
	output logic ir_tx,
	output logic ev_input_en,
	output logic periph_running
);

	if (SAMPLES_PER_BIT < 2 || SAMPLES_PER_BIT > 16 ||
		(SAMPLES_PER_BIT & (SAMPLES_PER_BIT - 1)) != 0) begin : g_chk
		$error("SAMPLES_PER_BIT must be a power of two from 2 to 16");
	end

	localparam logic [3:0] LAST_SAMPLE = 4'(SAMPLES_PER_BIT - 1);

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);

	////////////////////////////////////////////////////////////////////////

	typedef struct packed {
		logic [7:0] frame;
		logic [15:0] baud;
		logic [1:0] win_code;
		logic dbg_run;
		logic ev_disable;
		logic [7:0] pulse_code;
		logic [7:0] rdata;
		ufbc_pkg::ufbc_frame_cfg_t cfg;
		ufbc_pkg::ufbc_window_t win;
		logic [15:0] presc;
		logic [3:0] sub;
		logic sample_tick;
		logic bit_tick;
		ufbc_pkg::ufbc_ir_state_t ir_state;
		logic [7:0] ir_cnt;
		logic ir_out;
		logic ev_en;
		logic running;
	} ufbc_state_t;

	ufbc_state_t st;
	ufbc_state_t next_st;

	////////////////////////////////////////////////////////////////////////

	function automatic logic [3:0] char_bits(input logic [2:0] code);
		case (code)
			3'h0: char_bits = 4'h5;
			3'h1: char_bits = 4'h6;
			3'h2: char_bits = 4'h7;
			3'h6, 3'h7: char_bits = 4'h9;
			default: char_bits = 4'h8;
		endcase
	endfunction

	function automatic ufbc_pkg::ufbc_frame_cfg_t decode_frame(
		input logic [7:0] f);
		ufbc_pkg::ufbc_frame_cfg_t c;
		logic [1:0] par;
		logic [2:0] ch;
		c = '0;
		par = f[ufbc_pkg::PARITY_LSB +: 2];
		ch = f[ufbc_pkg::SIZE_LSB +: 3];
		c.mode = ufbc_pkg::ufbc_mode_t'(f[ufbc_pkg::MODE_LSB +: 2]);
		if (c.mode == ufbc_pkg::UFBC_MODE_SPI) begin
			// Frame fields have no meaning here, only order and phase
			c.spi_lsb_first = f[ufbc_pkg::ORDER_BIT];
			c.spi_sample_trailing = f[ufbc_pkg::PHASE_BIT];
			c.data_bits = 4'h8;
		end else begin
			// Reserved parity code 1 falls out as disabled
			c.parity_en = (par == ufbc_pkg::PAR_EVEN) ||
				(par == ufbc_pkg::PAR_ODD);
			c.parity_odd = (par == ufbc_pkg::PAR_ODD);
			c.two_stop_tx = f[ufbc_pkg::STOP_SEL_BIT];
			// One count for both directions; no receive stop field
			c.data_bits = char_bits(ch);
			c.nine_bit = (ch == ufbc_pkg::CH_9BIT_LOW) ||
				(ch == ufbc_pkg::CH_9BIT_HIGH);
			c.nine_high_first = (ch == ufbc_pkg::CH_9BIT_HIGH);
		end
		decode_frame = c;
	endfunction

	function automatic logic [5:0] window_tol(input logic [1:0] code);
		case (code)
			2'h0: window_tol = 6'h06;
			2'h1: window_tol = 6'h05;
			2'h2: window_tol = 6'h07;
			default: window_tol = 6'h08;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////

	always_comb begin
		logic [7:0] wmask;
		logic [7:0] pulse_len;
		logic pass;
		logic step;
		wmask = 8'hff;
		pulse_len = 8'h00;
		pass = 1'b0;
		step = 1'b0;
		next_st = st;
		next_st.sample_tick = 1'b0;
		next_st.bit_tick = 1'b0;
		next_st.rdata = 8'h00;
		next_st.running = st.dbg_run | ~cpu_halted;

		if (req.wr) begin
			case (req.addr)
				ufbc_pkg::OFS_FRAME: begin
					// Unused bits of the SPI view are cleared on the way in
					if (req.wdata[ufbc_pkg::MODE_LSB +: 2] ==
						ufbc_pkg::UFBC_MODE_SPI) begin
						wmask = ufbc_pkg::SPI_VIEW_MASK;
					end
					next_st.frame = req.wdata & wmask;
				end
				ufbc_pkg::OFS_BAUD_LO: begin
					next_st.baud[7:0] = req.wdata;
				end
				ufbc_pkg::OFS_BAUD_HI: begin
					next_st.baud[15:8] = req.wdata;
				end
				ufbc_pkg::OFS_WINDOW: begin
					next_st.win_code = req.wdata[ufbc_pkg::WINDOW_LSB +: 2];
				end
				ufbc_pkg::OFS_DBG: begin
					next_st.dbg_run = req.wdata[ufbc_pkg::RUN_BIT];
				end
				ufbc_pkg::OFS_EVC: begin
					next_st.ev_disable = req.wdata[ufbc_pkg::EV_DIS_BIT];
				end
				ufbc_pkg::OFS_PULSE: begin
					next_st.pulse_code = req.wdata;
				end
				default: begin
				end
			endcase
		end

		if (req.rd) begin
			case (req.addr)
				ufbc_pkg::OFS_FRAME: begin
					if (st.cfg.mode == ufbc_pkg::UFBC_MODE_SPI) begin
						next_st.rdata = st.frame &
							ufbc_pkg::SPI_VIEW_MASK;
					end else begin
						next_st.rdata = st.frame;
					end
				end
				ufbc_pkg::OFS_BAUD_LO: next_st.rdata = st.baud[7:0];
				ufbc_pkg::OFS_BAUD_HI: next_st.rdata = st.baud[15:8];
				ufbc_pkg::OFS_WINDOW: next_st.rdata = {st.win_code, 6'h00};
				ufbc_pkg::OFS_DBG: next_st.rdata = {7'h00, st.dbg_run};
				ufbc_pkg::OFS_EVC: next_st.rdata = {7'h00, st.ev_disable};
				ufbc_pkg::OFS_PULSE: next_st.rdata = st.pulse_code;
				default: next_st.rdata = 8'h00;
			endcase
		end

		// Decoded view follows the stored byte with no frame boundary wait
		next_st.cfg = decode_frame(next_st.frame);
		next_st.win = '0;
		if (receiver_speed_mode == ufbc_pkg::RX_CONSTRAINED) begin
			next_st.win.active = 1'b1;
			next_st.win.min_samples = ufbc_pkg::PAIR_SAMPLES -
				window_tol(next_st.win_code);
			next_st.win.max_samples = ufbc_pkg::PAIR_SAMPLES +
				window_tol(next_st.win_code);
		end

		// Events pass only while the block runs
		next_st.ev_en = ~next_st.ev_disable & next_st.running;

		// Prescaler: a divisor write restarts it and costs the current bit
		if (req.wr && (req.addr == ufbc_pkg::OFS_BAUD_LO ||
			req.addr == ufbc_pkg::OFS_BAUD_HI)) begin
			next_st.presc = next_st.baud;
			next_st.sub = 4'h0;
		end else if (next_st.running) begin
			if (st.presc == 16'h0000) begin
				next_st.presc = st.baud;
				next_st.sample_tick = 1'b1;
				if (st.sub == LAST_SAMPLE) begin
					next_st.sub = 4'h0;
					next_st.bit_tick = 1'b1;
				end else begin
					next_st.sub = st.sub + 4'h1;
				end
			end else begin
				next_st.presc = st.presc - 16'h0001;
			end
		end

		// Infrared pulse shaping
		pass = (st.cfg.mode != ufbc_pkg::UFBC_MODE_IR) ||
			(st.pulse_code == ufbc_pkg::PULSE_PASS);
		if (pass) begin
			next_st.ir_state = ufbc_pkg::UFBC_IR_IDLE;
			next_st.ir_cnt = 8'h00;
			next_st.ir_out = tx_line;
		end else if (next_st.running) begin
			case (st.ir_state)
				ufbc_pkg::UFBC_IR_IDLE: begin
					if (st.pulse_code == ufbc_pkg::PULSE_FRACTION) begin
						pulse_len = ufbc_pkg::FRACTION_SAMPLES;
					end else begin
						pulse_len = st.pulse_code;
					end
					// Zero bits are sent as a pulse on the bit edge
					if (next_st.bit_tick && !tx_line) begin
						next_st.ir_state = ufbc_pkg::UFBC_IR_PULSE;
						next_st.ir_cnt = pulse_len;
					end
				end
				ufbc_pkg::UFBC_IR_PULSE: begin
					if (st.pulse_code == ufbc_pkg::PULSE_FRACTION) begin
						step = next_st.sample_tick;
					end else begin
						step = 1'b1;
					end
					if (step) begin
						if (st.ir_cnt <= 8'h01) begin
							next_st.ir_state = ufbc_pkg::UFBC_IR_IDLE;
							next_st.ir_cnt = 8'h00;
						end else begin
							next_st.ir_cnt = st.ir_cnt - 8'h01;
						end
					end
				end
				default: begin
					next_st.ir_state = ufbc_pkg::UFBC_IR_IDLE;
				end
			endcase
			next_st.ir_out = (next_st.ir_state == ufbc_pkg::UFBC_IR_PULSE);
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			st <= '0;
			st.frame <= ufbc_pkg::RST_FRAME;
			st.baud <= ufbc_pkg::RST_BAUD;
			st.win_code <= ufbc_pkg::RST_WINDOW[ufbc_pkg::WINDOW_LSB +: 2];
			st.dbg_run <= ufbc_pkg::RST_DBG[ufbc_pkg::RUN_BIT];
			st.ev_disable <= ufbc_pkg::RST_EVC[ufbc_pkg::EV_DIS_BIT];
			st.pulse_code <= ufbc_pkg::RST_PULSE;
			st.cfg <= decode_frame(ufbc_pkg::RST_FRAME);
			st.ir_state <= ufbc_pkg::UFBC_IR_IDLE;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign rdata = st.rdata;
	assign cfg = st.cfg;
	assign win = st.win;
	assign baud_div = st.baud;
	assign sample_tick = st.sample_tick;
	assign bit_tick = st.bit_tick;
	assign ir_tx = st.ir_out;
	assign ev_input_en = st.ev_en;
	assign periph_running = st.running;

	////////////////////////////////////////////////////////////////////////

	a_parity_decode: assert property (
		(st.cfg.mode != ufbc_pkg::UFBC_MODE_SPI) |->
		(st.cfg.parity_en == st.frame[5]) &&
		(st.cfg.parity_odd == (st.frame[5:4] == 2'h3)))
		else $error("parity decode differs from stored field");

	a_stop_select: assert property (
		(st.cfg.mode != ufbc_pkg::UFBC_MODE_SPI) |->
		(st.cfg.two_stop_tx == st.frame[3]))
		else $error("stop bit count differs from select");

	a_char_size: assert property (
		(st.cfg.mode != ufbc_pkg::UFBC_MODE_SPI &&
		st.frame[2:0] == 3'h1) |-> (st.cfg.data_bits == 4'h6))
		else $error("character size code 1 not six bits");

	a_nine_order: assert property (
		(st.cfg.mode != ufbc_pkg::UFBC_MODE_SPI && st.frame[2:0] == 3'h7)
		|-> st.cfg.nine_bit && st.cfg.nine_high_first &&
		(st.cfg.data_bits == 4'h9))
		else $error("nine bit high first not decoded");

	a_spi_view: assert property (
		(ce && req.rd && req.addr == ufbc_pkg::OFS_FRAME &&
		st.cfg.mode == ufbc_pkg::UFBC_MODE_SPI)
		|=> ((rdata & 8'h39) == 8'h00) && (rdata[7:6] == 2'h3))
		else $error("host SPI view shows hidden bits");

	a_order_now: assert property (
		(ce && req.wr && req.addr == ufbc_pkg::OFS_FRAME &&
		req.wdata[7:6] == 2'h3)
		|=> (cfg.spi_lsb_first == $past(req.wdata[2])) &&
		(cfg.spi_sample_trailing == $past(req.wdata[1])))
		else $error("data order or phase not applied next cycle");

	a_baud_reload: assert property (
		(ce && req.wr && req.addr == ufbc_pkg::OFS_BAUD_HI)
		|=> (st.presc == st.baud) && (st.sub == 4'h0) &&
		(st.baud[15:8] == $past(req.wdata)))
		else $error("prescaler not reloaded by divisor write");

	a_bit_sample: assert property (
		bit_tick |-> sample_tick && ($past(st.sub) == LAST_SAMPLE))
		else $error("bit tick not on the last sample");

	a_window_0: assert property (
		(win.active && st.win_code == 2'h0) |->
		(win.min_samples == 6'h1a) && (win.max_samples == 6'h26))
		else $error("window code 0 is not 32 plus or minus 6");

	a_halt_freeze: assert property (
		// Halt follows the live halt input, not the registered run flag
		(ce && cpu_halted && !st.dbg_run && !req.wr) |=>
		(st.presc == $past(st.presc)) && !sample_tick)
		else $error("prescaler moved while halted");

	a_event_gate: assert property (
		ev_input_en |-> !st.ev_disable && periph_running)
		else $error("event input open while disabled");

	a_ir_pass: assert property (
		(ce && (st.cfg.mode != ufbc_pkg::UFBC_MODE_IR ||
		st.pulse_code == 8'hff)) |=> (ir_tx == $past(tx_line)))
		else $error("pass-through does not follow transmit line");

endmodule // ufbc_core

`default_nettype wire

// >>> sim/ufbc_ir_peer.sv
`timescale 1ns/1ps
`default_nettype none

// Remote infrared receiver: measures the width of each light pulse
module ufbc_ir_peer (
	input wire logic mclk,
	input wire logic srst,
	input wire logic ir_rx,
	output logic [8:0] last_len
);
	logic [8:0] run;

	always_ff @(posedge mclk) begin
		if (srst) begin
			run <= 9'h000;
			last_len <= 9'h000;
		end else if (ir_rx) begin
			run <= run + 9'h001;
		end else begin
			// Latch only on a falling edge so idle time never overwrites it
			if (run != 9'h000) begin
				last_len <= run;
			end
			run <= 9'h000;
		end
	end
endmodule // ufbc_ir_peer

`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic ce = 1'b1;
	ufbc_pkg::ufbc_bus_req_t req = '0;
	logic [1:0] receiver_speed_mode = 2'h0;
	logic cpu_halted = 1'b0;
	logic tx_line = 1'b1;
	logic [7:0] rdata;
	ufbc_pkg::ufbc_frame_cfg_t cfg;
	ufbc_pkg::ufbc_window_t win;
	logic [15:0] baud_div;
	logic sample_tick, bit_tick, ir_tx, ev_input_en, periph_running;
	logic [8:0] last_len;
	int error_cnt = 0;
	int checked = 0;
	int cycles = 0;
	int n;
	logic [7:0] v;
	logic [5:0] tol;

	always #20 mclk = ~mclk;

	ufbc_core ufbc_core_i (.mclk(mclk), .srst(srst), .ce(ce), .req(req),
		.receiver_speed_mode(receiver_speed_mode), .cpu_halted(cpu_halted),
		.tx_line(tx_line), .rdata(rdata), .cfg(cfg), .win(win),
		.baud_div(baud_div), .sample_tick(sample_tick), .bit_tick(bit_tick),
		.ir_tx(ir_tx), .ev_input_en(ev_input_en),
		.periph_running(periph_running));

	ufbc_ir_peer ufbc_ir_peer_i (.mclk(mclk), .srst(srst), .ir_rx(ir_tx),
		.last_len(last_len));

	////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge mclk);
		req.wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge mclk);
		req.rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic chk(input string s, input logic [15:0] e,
			input logic [15:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", s, e, g);
		end
	endtask

	task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
		rd(a, v);
		chk("rdata", {8'h00, e}, {8'h00, v});
	endtask

	task automatic settle();
		repeat (2) @(posedge mclk);
		#1;
	endtask

	function automatic logic pick(input int sel);
		case (sel)
			0: return sample_tick;
			1: return bit_tick;
			default: return ir_tx;
		endcase
	endfunction

	// Bounded so a dead prescaler shows up as a wrong count, not a hang
	task automatic wait_hi(input int sel, output int k);
		k = 0;
		do begin
			@(posedge mclk);
			#1;
			k++;
		end while (pick(sel) !== 1'b1 && k < 2000);
	endtask

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge mclk);
		srst <= 1'b0;
		for (int a = 7; a < 14; a++) begin
			chk_rd(a[3:0], (a == 7) ? 8'h03 : 8'h00);
		end
		chk_rd(4'he, 8'h00);
		chk_rd(4'h0, 8'h00);
		chk("data_bits", 16'h0008, {12'h000, cfg.data_bits});
		wr(4'hb, 8'hff);
		chk_rd(4'hb, 8'h01);
		wr(4'ha, 8'hff);
		chk_rd(4'ha, 8'hc0);
		wr(4'hc, 8'hff);
		chk_rd(4'hc, 8'h01);
		wr(4'hd, 8'hff);
		chk_rd(4'hd, 8'hff);
		wr(4'he, 8'hff);
		chk_rd(4'he, 8'h00);
		@(posedge mclk);
		ce <= 1'b0;
		wr(4'hd, 8'h55);
		@(posedge mclk);
		ce <= 1'b1;
		chk_rd(4'hd, 8'hff);
		done("registers");

		for (int c = 0; c < 8; c++) begin
			wr(4'h7, {2'h0, c[1:0], c[0], c[2:0]});
			chk_rd(4'h7, {2'h0, c[1:0], c[0], c[2:0]});
			chk("parity_en", 16'(c[1]), 16'(cfg.parity_en));
			chk("parity_odd", 16'(c[1:0] == 2'h3), 16'(cfg.parity_odd));
			chk("two_stop", 16'(c[0]), 16'(cfg.two_stop_tx));
			v = (c < 4) ? 8'(c + 5) : (c < 6) ? 8'h08 : 8'h09;
			chk("bits", 16'(v), 16'(cfg.data_bits));
			chk("nine", 16'(c >= 6), 16'(cfg.nine_bit));
			chk("nine_hi", 16'(c == 7), 16'(cfg.nine_high_first));
		end
		for (int m = 0; m < 3; m++) begin
			wr(4'h7, {m[1:0], 6'h03});
			chk("mode", 16'(m), 16'(cfg.mode));
		end
		wr(4'h7, 8'hff);
		chk_rd(4'h7, 8'hc6);
		chk("mode", 16'h0003, 16'(cfg.mode));
		chk("lsb_first", 16'h0001, 16'(cfg.spi_lsb_first));
		chk("trailing", 16'h0001, 16'(cfg.spi_sample_trailing));
		chk("spi_par", 16'h0000, 16'(cfg.parity_en));
		wr(4'h7, 8'hc2);
		chk("lsb_first", 16'h0000, 16'(cfg.spi_lsb_first));
		chk("trailing", 16'h0001, 16'(cfg.spi_sample_trailing));
		done("frame");

		wr(4'h8, 8'h34);
		wr(4'h9, 8'h12);
		chk("baud_div", 16'h1234, baud_div);
		chk_rd(4'h9, 8'h12);
		wr(4'h9, 8'h00);
		wr(4'h8, 8'h01);
		wait_hi(0, n);
		chk("reload", 16'h0002, n[15:0]);
		wait_hi(0, n);
		chk("sample_gap", 16'h0002, n[15:0]);
		wait_hi(1, n);
		wait_hi(1, n);
		chk("bit_gap", 16'h0020, n[15:0]);
		done("baud");

		@(posedge mclk);
		cpu_halted <= 1'b1;
		wr(4'hb, 8'h00);
		settle();
		chk("running", 16'h0000, 16'(periph_running));
		n = 0;
		repeat (8) begin
			@(posedge mclk);
			#1;
			n += (sample_tick === 1'b1);
		end
		chk("halt_ticks", 16'h0000, n[15:0]);
		wr(4'hb, 8'h01);
		settle();
		chk("running", 16'h0001, 16'(periph_running));
		chk("ev_en", 16'h0000, 16'(ev_input_en));
		wr(4'hc, 8'h00);
		settle();
		chk("ev_en", 16'h0001, 16'(ev_input_en));
		@(posedge mclk);
		cpu_halted <= 1'b0;
		done("debug");

		@(posedge mclk);
		receiver_speed_mode <= 2'h3;
		for (int k = 0; k < 4; k++) begin
			wr(4'ha, {k[1:0], 6'h00});
			settle();
			tol = (k == 0) ? 6'h06 : (k == 1) ? 6'h05 :
				(k == 2) ? 6'h07 : 6'h08;
			chk("win_on", 16'h0001, 16'(win.active));
			chk("win_min", 16'(6'h20 - tol), 16'(win.min_samples));
			chk("win_max", 16'(6'h20 + tol), 16'(win.max_samples));
		end
		@(posedge mclk);
		receiver_speed_mode <= 2'h0;
		settle();
		chk("win_on", 16'h0000, 16'(win.active));
		done("window");

		// Pulse length is set before the line starts sending
		wr(4'h7, 8'h83);
		wr(4'hd, 8'h05);
		@(posedge mclk);
		tx_line <= 1'b0;
		wait_hi(1, n);
		wait_hi(1, n);
		repeat (12) @(posedge mclk);
		chk("pulse_fixed", 16'h0005, 16'(last_len));
		wr(4'hd, 8'h00);
		wait_hi(1, n);
		wait_hi(1, n);
		repeat (12) @(posedge mclk);
		chk("pulse_frac", 16'h0006, 16'(last_len));
		wr(4'hd, 8'hff);
		@(posedge mclk);
		tx_line <= 1'b1;
		settle();
		chk("pass_hi", 16'h0001, 16'(ir_tx));
		@(posedge mclk);
		tx_line <= 1'b0;
		settle();
		chk("pass_lo", 16'h0000, 16'(ir_tx));
		done("infrared");
		stop_test();
	end
endmodule // testbench

`default_nettype wire
